// file: core/his_pkg.sv
// Constants shared by the host interface select block.
package his_pkg;
	// Seven-bit slave addresses chosen by the address strap.
	localparam logic [6:0] I2C_ADDR_STRAP_LOW = 7'h66;
	localparam logic [6:0] I2C_ADDR_STRAP_HIGH = 7'h67;
	// Strap level that selects the SPI port; low selects I2C.
	localparam logic STRAP_SELECT_SPI = 1'b1;
	// Highest link rates that the host may use.
	localparam int I2C_MAX_RATE_HZ = 400_000;
	localparam int SPI_MAX_RATE_HZ = 4_000_000;
	// Core clock and start-up timing.
	localparam int CLK_PERIOD_NS = 5;
	localparam int STARTUP_TIME_MS = 110;
	localparam int STARTUP_CYCLES = (STARTUP_TIME_MS * 1_000_000) / CLK_PERIOD_NS;
	// Core cycles the strap synchronisers need before the capture.
	localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;
	// Bits in one link byte.
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// I2C slave states.
	typedef enum logic [2:0] {
		HIS_I2C_IDLE,
		HIS_I2C_ADDR,
		HIS_I2C_ADDR_ACK,
		HIS_I2C_WR_BYTE,
		HIS_I2C_WR_ACK,
		HIS_I2C_RD_BYTE,
		HIS_I2C_RD_ACK
	} his_i2c_state_e;
endpackage : his_pkg

// file: core/his_spi_if.sv
// Signals that pass between the core logic and the SPI link logic.
`timescale 1ns/100ps
interface his_spi_if;
	logic [7:0] tx_word;
	logic [7:0] rx_byte;
	logic rx_toggle;
	modport core (output tx_word, input rx_byte, input rx_toggle);
	modport link (input tx_word, output rx_byte, output rx_toggle);
endinterface : his_spi_if

// file: core/his_spi_link.sv
// SPI mode 0 shift logic that runs on the host serial clock.
`timescale 1ns/100ps
module his_spi_link (
	input wire logic spi_sck_clk_in,
	input wire logic frame_rst_n_in,
	input wire logic rst_n_in,
	input wire logic mosi_in,
	output logic miso_out,
	his_spi_if.link link_if
);
	logic [2:0] bit_cnt_reg;
	logic [6:0] rx_shift_reg;
	logic [7:0] tx_shift_reg;
	logic first_bit_reg;

	// Receive side samples on the rising edge; the frame select resets the bit count.
	always_ff @(posedge spi_sck_clk_in or negedge frame_rst_n_in) begin
		if (!frame_rst_n_in) begin
			bit_cnt_reg <= 3'h0;
			rx_shift_reg <= 7'h00;
		end else begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			rx_shift_reg <= {rx_shift_reg[5:0], mosi_in};
		end
	end

	// The finished byte and its toggle survive the end of a frame, so only the main reset clears them.
	always_ff @(posedge spi_sck_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			link_if.rx_byte <= 8'h00;
			link_if.rx_toggle <= 1'b0;
		end else if (bit_cnt_reg == 3'h7) begin
			link_if.rx_byte <= {rx_shift_reg, mosi_in};
			link_if.rx_toggle <= ~link_if.rx_toggle;
		end
	end

	// Transmit side shifts on the falling edge, one bit behind the sampled bit.
	always_ff @(negedge spi_sck_clk_in or negedge frame_rst_n_in) begin
		if (!frame_rst_n_in) begin
			tx_shift_reg <= 8'h00;
		end else if (bit_cnt_reg == 3'h1) begin
			tx_shift_reg <= {link_if.tx_word[6:0], 1'b0};
		end else begin
			tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
		end
	end

	// Word and shift register trade places on falling edges and at the frame reset only, so the output never moves on a rising edge.
	always_ff @(negedge spi_sck_clk_in or negedge frame_rst_n_in) begin
		if (!frame_rst_n_in) begin
			first_bit_reg <= 1'b1;
		end else begin
			first_bit_reg <= (bit_cnt_reg == 3'h0);
		end
	end

	// The first bit must stand before the first rising edge, so it comes straight from the word.
	assign miso_out = first_bit_reg ? link_if.tx_word[7] : tx_shift_reg[7];
endmodule : his_spi_link

// file: core/his_host_select.sv
// Host interface front end: strap sampling, pin routing, I2C and SPI slaves, host interrupt.
// Functional notes
// - Interface strap sampled once after reset: low gives I2C, high gives SPI.
// - In SPI mode the interface strap pin becomes the driven serial data output.
// - I2C address is 0x66 with address strap low, 0x67 with it high.
// - I2C port works at bus clocks up to 400 kHz; host runs at 400 kHz.
// - SPI port works at serial clocks up to 4 MHz; host clocks it at 31.25 MHz.
// - I2C uses first shared pin as data, second as clock, plus interrupt.
// - SPI uses address strap as MOSI, interface strap as MISO, SCK, select.
// - The SPI port keeps working with select tied low permanently.
// - SPI mode 0: clock idles low, sample on rise, shift on fall.
// - Reports are collected on interrupt; the line goes low while reports pend.
// - After reset the interrupt first goes low for a greeting, about 110 ms.
`timescale 1ns/100ps
module his_host_select #(
	parameter int STARTUP_CYCLES = his_pkg::STARTUP_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic spi_sck_clk_in,
	input wire logic shared_data_or_sclk_pin_in,
	output logic shared_data_or_sclk_pin_out,
	output logic shared_data_or_sclk_pin_oe_out,
	input wire logic shared_clock_or_select_pin_in,
	input wire logic address_strap_or_mosi_pin_in,
	input wire logic interface_strap_or_miso_pin_in,
	output logic interface_strap_or_miso_pin_out,
	output logic interface_strap_or_miso_pin_oe_out,
	output logic host_interrupt_n_out,
	output logic host_interrupt_n_oe_out,
	input wire logic [7:0] tx_data_in,
	input wire logic report_pending_in,
	output logic tx_taken_out,
	output logic [7:0] rx_data_out,
	output logic rx_valid_out,
	output logic straps_ready_out,
	output logic spi_mode_out,
	output logic [6:0] i2c_addr_out
);
	his_spi_if spi_if ();
	logic [1:0] strap_if_sync_reg;
	logic [1:0] strap_addr_sync_reg;
	logic [1:0] settle_cnt_reg;
	logic straps_ready_reg;
	logic spi_mode_reg;
	logic addr_bit_reg;
	logic [6:0] own_addr;
	logic [2:0] scl_sync_reg;
	logic [2:0] sda_sync_reg;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic i2c_active;
	his_pkg::his_i2c_state_e i2c_state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_shift_reg;
	logic sda_oe_reg;
	logic master_nack_reg;
	logic rd_dir_reg;
	logic [2:0] spi_tog_sync_reg;
	logic spi_byte_done;
	logic [7:0] spi_tx_word_reg;
	logic spi_frame_rst_n;
	logic spi_miso;
	logic [31:0] startup_cnt_reg;
	logic greeting_pending_reg;
	logic host_read_done_reg;
	logic i2c_rx_pulse_reg;
	logic i2c_tx_pulse_reg;
	logic [7:0] i2c_rx_data_reg;

	// Straps are pins, so each passes two flip-flops before anything looks at it.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			strap_if_sync_reg <= 2'h0;
			strap_addr_sync_reg <= 2'h0;
		end else begin
			strap_if_sync_reg <= {strap_if_sync_reg[0], interface_strap_or_miso_pin_in};
			strap_addr_sync_reg <= {strap_addr_sync_reg[0], address_strap_or_mosi_pin_in};
		end
	end

	// Capture both straps once the synchronisers hold levels from after the release; later changes are ignored.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			settle_cnt_reg <= 2'h0;
			straps_ready_reg <= 1'b0;
			spi_mode_reg <= 1'b0;
			addr_bit_reg <= 1'b0;
		end else if (!straps_ready_reg) begin
			if (settle_cnt_reg == his_pkg::STRAP_SETTLE_CYCLES) begin
				straps_ready_reg <= 1'b1;
				spi_mode_reg <= (strap_if_sync_reg[1] == his_pkg::STRAP_SELECT_SPI);
				addr_bit_reg <= strap_addr_sync_reg[1];
			end else begin
				settle_cnt_reg <= settle_cnt_reg + 2'h1;
			end
		end
	end

	assign own_addr = addr_bit_reg ? his_pkg::I2C_ADDR_STRAP_HIGH : his_pkg::I2C_ADDR_STRAP_LOW;
	assign i2c_active = straps_ready_reg && !spi_mode_reg;

	// Bus lines sampled at 200 MHz; even the fastest legal I2C clock gives hundreds of samples per phase.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], shared_clock_or_select_pin_in};
			sda_sync_reg <= {sda_sync_reg[1:0], shared_data_or_sclk_pin_in};
		end
	end

	// Bus events are taken from the second and third stages only.
	assign scl_rise = scl_sync_reg[1] && !scl_sync_reg[2];
	assign scl_fall = !scl_sync_reg[1] && scl_sync_reg[2];
	assign bus_start = scl_sync_reg[1] && scl_sync_reg[2] && !sda_sync_reg[1] && sda_sync_reg[2];
	assign bus_stop = scl_sync_reg[1] && scl_sync_reg[2] && sda_sync_reg[1] && !sda_sync_reg[2];

	// I2C slave sequencer; data is sampled on clock rise and the data line changes after clock fall.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			i2c_state_reg <= his_pkg::HIS_I2C_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_shift_reg <= 8'h00;
			sda_oe_reg <= 1'b0;
			master_nack_reg <= 1'b0;
			rd_dir_reg <= 1'b0;
		end else if (!i2c_active || bus_stop) begin
			i2c_state_reg <= his_pkg::HIS_I2C_IDLE;
			sda_oe_reg <= 1'b0;
		end else if (bus_start) begin
			i2c_state_reg <= his_pkg::HIS_I2C_ADDR;
			bit_cnt_reg <= 4'h0;
			sda_oe_reg <= 1'b0;
		end else if (scl_rise) begin
			shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
			bit_cnt_reg <= bit_cnt_reg + 4'h1;
			if (i2c_state_reg == his_pkg::HIS_I2C_RD_ACK) begin
				master_nack_reg <= sda_sync_reg[1];
			end
		end else if (scl_fall) begin
			unique case (i2c_state_reg)
				his_pkg::HIS_I2C_IDLE: begin
					sda_oe_reg <= 1'b0;
				end
				his_pkg::HIS_I2C_ADDR: begin
					if (bit_cnt_reg == his_pkg::BYTE_BITS) begin
						if (shift_reg[7:1] == own_addr) begin
							i2c_state_reg <= his_pkg::HIS_I2C_ADDR_ACK;
							sda_oe_reg <= 1'b1;
							// The ninth clock shifts the acknowledge in, so the direction bit is kept apart.
							rd_dir_reg <= shift_reg[0];
						end else begin
							i2c_state_reg <= his_pkg::HIS_I2C_IDLE;
						end
					end
				end
				his_pkg::HIS_I2C_ADDR_ACK, his_pkg::HIS_I2C_WR_ACK: begin
					bit_cnt_reg <= 4'h0;
					if ((i2c_state_reg == his_pkg::HIS_I2C_ADDR_ACK) && rd_dir_reg) begin
						i2c_state_reg <= his_pkg::HIS_I2C_RD_BYTE;
						tx_shift_reg <= tx_data_in;
						sda_oe_reg <= ~tx_data_in[7];
					end else begin
						i2c_state_reg <= his_pkg::HIS_I2C_WR_BYTE;
						sda_oe_reg <= 1'b0;
					end
				end
				his_pkg::HIS_I2C_WR_BYTE: begin
					if (bit_cnt_reg == his_pkg::BYTE_BITS) begin
						i2c_state_reg <= his_pkg::HIS_I2C_WR_ACK;
						sda_oe_reg <= 1'b1;
					end
				end
				his_pkg::HIS_I2C_RD_BYTE: begin
					if (bit_cnt_reg == his_pkg::BYTE_BITS) begin
						i2c_state_reg <= his_pkg::HIS_I2C_RD_ACK;
						sda_oe_reg <= 1'b0;
					end else begin
						tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
						sda_oe_reg <= ~tx_shift_reg[6];
					end
				end
				his_pkg::HIS_I2C_RD_ACK: begin
					bit_cnt_reg <= 4'h0;
					if (master_nack_reg) begin
						i2c_state_reg <= his_pkg::HIS_I2C_IDLE;
						sda_oe_reg <= 1'b0;
					end else begin
						i2c_state_reg <= his_pkg::HIS_I2C_RD_BYTE;
						tx_shift_reg <= tx_data_in;
						sda_oe_reg <= ~tx_data_in[7];
					end
				end
			endcase
		end
	end

	// One-cycle user strobes for I2C bytes written by the host and bytes fetched for it.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			i2c_rx_pulse_reg <= 1'b0;
			i2c_tx_pulse_reg <= 1'b0;
			i2c_rx_data_reg <= 8'h00;
		end else begin
			i2c_rx_pulse_reg <= i2c_active && scl_fall && !bus_start && !bus_stop
				&& (i2c_state_reg == his_pkg::HIS_I2C_WR_BYTE) && (bit_cnt_reg == his_pkg::BYTE_BITS);
			i2c_tx_pulse_reg <= i2c_active && scl_fall && !bus_start && !bus_stop
				&& (((i2c_state_reg == his_pkg::HIS_I2C_ADDR_ACK) && rd_dir_reg)
				|| ((i2c_state_reg == his_pkg::HIS_I2C_RD_ACK) && !master_nack_reg));
			if (i2c_state_reg == his_pkg::HIS_I2C_WR_BYTE) begin
				i2c_rx_data_reg <= shift_reg;
			end
		end
	end

	// SPI frames reset the link counters while select is high; a select tied low never resets them.
	assign spi_frame_rst_n = rst_n_in && straps_ready_reg && spi_mode_reg && !shared_clock_or_select_pin_in;

	his_spi_link u_spi_link (
		.spi_sck_clk_in(spi_sck_clk_in),
		.frame_rst_n_in(spi_frame_rst_n),
		.rst_n_in(rst_n_in),
		.mosi_in(address_strap_or_mosi_pin_in),
		.miso_out(spi_miso),
		.link_if(spi_if.link)
	);

	// The byte toggle crosses by two flip-flops; the third stage finds its edge.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			spi_tog_sync_reg <= 3'h0;
		end else begin
			spi_tog_sync_reg <= {spi_tog_sync_reg[1:0], spi_if.rx_toggle};
		end
	end
	assign spi_byte_done = spi_tog_sync_reg[1] ^ spi_tog_sync_reg[2];

	// The next SPI byte is latched when one finishes or while select is high; half a 4 MHz clock period leaves ample margin.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			spi_tx_word_reg <= 8'h00;
		end else if (spi_byte_done || scl_sync_reg[1]) begin
			spi_tx_word_reg <= tx_data_in;
		end
	end
	assign spi_if.tx_word = spi_tx_word_reg;

	// User receive port, fed by whichever slave the strap chose.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_data_out <= 8'h00;
			rx_valid_out <= 1'b0;
			tx_taken_out <= 1'b0;
		end else begin
			rx_valid_out <= spi_mode_reg ? spi_byte_done : i2c_rx_pulse_reg;
			tx_taken_out <= spi_mode_reg ? spi_byte_done : i2c_tx_pulse_reg;
			if (spi_mode_reg && spi_byte_done) begin
				rx_data_out <= spi_if.rx_byte;
			end else if (!spi_mode_reg && i2c_rx_pulse_reg) begin
				rx_data_out <= i2c_rx_data_reg;
			end
		end
	end

	// A host read counts as done at an I2C read ended by a not-acknowledge or at any whole SPI byte.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			host_read_done_reg <= 1'b0;
		end else begin
			host_read_done_reg <= (spi_mode_reg && spi_byte_done) || (i2c_active && scl_fall
				&& (i2c_state_reg == his_pkg::HIS_I2C_RD_ACK) && master_nack_reg);
		end
	end

	// Start-up timer raises the greeting; setting wins over a read that finishes in the same cycle.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			startup_cnt_reg <= 32'h0;
			greeting_pending_reg <= 1'b0;
		end else if (startup_cnt_reg < 32'(STARTUP_CYCLES)) begin
			startup_cnt_reg <= startup_cnt_reg + 32'h1;
			if (startup_cnt_reg == 32'(STARTUP_CYCLES - 1)) begin
				greeting_pending_reg <= 1'b1;
			end
		end else if (host_read_done_reg) begin
			greeting_pending_reg <= 1'b0;
		end
	end

	// Pin routing: the interrupt is open drain, the pull-up returns it high when released.
	assign host_interrupt_n_out = 1'b0;
	assign host_interrupt_n_oe_out = straps_ready_reg && (greeting_pending_reg || report_pending_in);
	assign shared_data_or_sclk_pin_out = 1'b0;
	assign shared_data_or_sclk_pin_oe_out = i2c_active && sda_oe_reg;
	assign interface_strap_or_miso_pin_out = spi_miso;
	assign interface_strap_or_miso_pin_oe_out = straps_ready_reg && spi_mode_reg;
	assign straps_ready_out = straps_ready_reg;
	assign spi_mode_out = spi_mode_reg;
	assign i2c_addr_out = own_addr;
endmodule : his_host_select

// file: tb/his_host_select_props.sv
// Port checker for the host interface select block.
`timescale 1ns/100ps
module his_props_chk #(
	parameter int STARTUP_CYCLES = 200
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic shared_data_or_sclk_pin_out,
	input wire logic shared_data_or_sclk_pin_oe_out,
	input wire logic address_strap_or_mosi_pin_in,
	input wire logic interface_strap_or_miso_pin_in,
	input wire logic interface_strap_or_miso_pin_oe_out,
	input wire logic host_interrupt_n_out,
	input wire logic host_interrupt_n_oe_out,
	input wire logic report_pending_in,
	input wire logic tx_taken_out,
	input wire logic rx_valid_out,
	input wire logic straps_ready_out,
	input wire logic spi_mode_out,
	input wire logic [6:0] i2c_addr_out
);
	logic [31:0] cyc_reg;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Edges since reset release; it saturates so a long run cannot wrap into the greeting window.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) cyc_reg <= 32'h0;
		else if (cyc_reg != 32'hFFFFFFFF) cyc_reg <= cyc_reg + 32'h1;
	end
	chk_od_low: assert property (!shared_data_or_sclk_pin_out && !host_interrupt_n_out)
		else $error("open drain output drives high");
	chk_spi_sda_quiet: assert property (spi_mode_out |-> !shared_data_or_sclk_pin_oe_out)
		else $error("data pin pulled in spi mode");
	chk_miso_oe_mode: assert property (straps_ready_out |-> interface_strap_or_miso_pin_oe_out == spi_mode_out)
		else $error("miso enable wrong for mode");
	chk_mode_strap: assert property ($rose(straps_ready_out) |-> spi_mode_out == $past(interface_strap_or_miso_pin_in))
		else $error("mode differs from strap");
	chk_addr_strap: assert property ($rose(straps_ready_out) |->
		i2c_addr_out == {6'h33, $past(address_strap_or_mosi_pin_in)})
		else $error("address differs from strap");
	chk_mode_hold: assert property (straps_ready_out |=> straps_ready_out && $stable(spi_mode_out))
		else $error("mode changed in session");
	chk_irq_pending: assert property (straps_ready_out && report_pending_in |-> host_interrupt_n_oe_out)
		else $error("interrupt released while pending");
	chk_irq_early: assert property (cyc_reg < STARTUP_CYCLES - 1 && !report_pending_in |-> !host_interrupt_n_oe_out)
		else $error("interrupt before greeting time");
	chk_greet_time: assert property (cyc_reg == STARTUP_CYCLES + 1 |-> host_interrupt_n_oe_out)
		else $error("greeting interrupt missing");
	chk_spi_pair: assert property (spi_mode_out && rx_valid_out |-> tx_taken_out)
		else $error("spi byte without transmit hand-off");
	cover property (rx_valid_out && spi_mode_out);
	cover property (tx_taken_out && !spi_mode_out);
	cover property ($rose(host_interrupt_n_oe_out));
	cover property (shared_data_or_sclk_pin_oe_out);
endmodule : his_props_chk
bind his_host_select his_props_chk #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (.ref_clk_in, .rst_n_in,
	.shared_data_or_sclk_pin_out, .shared_data_or_sclk_pin_oe_out, .address_strap_or_mosi_pin_in,
	.interface_strap_or_miso_pin_in, .interface_strap_or_miso_pin_oe_out, .host_interrupt_n_out,
	.host_interrupt_n_oe_out, .report_pending_in, .tx_taken_out, .rx_valid_out, .straps_ready_out,
	.spi_mode_out, .i2c_addr_out);

// file: tb/his_host_model.sv
// Host master model that works the shared pins as I2C or SPI master.
`timescale 1ns/100ps
module his_host_model (
	input wire logic sda_in,
	input wire logic miso_in,
	output logic scl_nss_out,
	output logic sda_low_out,
	output logic sck_out,
	output logic mosi_out
);
	localparam int Q = 625;
	// Idle bus: clock and select high, data released, serial clock parked low.
	initial begin
		scl_nss_out = 1'b1;
		sda_low_out = 1'b0;
		sck_out = 1'b0;
		mosi_out = 1'b0;
	end
	// One bit at 400 kHz; data only moves while the clock is low.
	task automatic i2c_bit(input logic v, output logic r);
		sda_low_out = !v;
		#Q scl_nss_out = 1'b1;
		#Q r = sda_in;
		#Q scl_nss_out = 1'b0;
		#Q;
	endtask : i2c_bit
	// A released ninth bit reads the slave acknowledge, or gives the closing not-acknowledge of a read.
	task automatic i2c_byte(input logic [7:0] b, output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			i2c_bit(b[i], r[i]);
		end
		i2c_bit(1'b1, ack);
	endtask : i2c_byte
	task automatic i2c_start();
		sda_low_out = 1'b0;
		#Q scl_nss_out = 1'b1;
		#Q sda_low_out = 1'b1;
		#Q scl_nss_out = 1'b0;
	endtask : i2c_start
	task automatic i2c_stop();
		sda_low_out = 1'b1;
		#Q scl_nss_out = 1'b1;
		#Q sda_low_out = 1'b0;
		#Q;
	endtask : i2c_stop
	// Mode 0: shift on the falling edge, sample on the rising edge.
	task automatic spi_byte(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			mosi_out = b[i];
			#16 sck_out = 1'b1;
			r[i] = miso_in;
			#16 sck_out = 1'b0;
		end
	endtask : spi_byte
	task automatic set_sel(input logic v);
		scl_nss_out = v;
	endtask : set_sel
endmodule : his_host_model

// file: tb/tb_top.sv
// Self-checking bench for the host interface select block.
`timescale 1ns/100ps
module tb_top;
	localparam int SU = 200;
	logic ref_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic spi_s = 1'b0;
	logic ifs = 1'b0;
	logic ads = 1'b1;
	logic [7:0] tx_data_in = 8'h00;
	logic report_pending_in = 1'b0;
	logic scl_nss, sda_low, sck, mosi;
	logic shared_data_or_sclk_pin_out, shared_data_or_sclk_pin_oe_out, interface_strap_or_miso_pin_out;
	logic interface_strap_or_miso_pin_oe_out, host_interrupt_n_out, host_interrupt_n_oe_out;
	logic tx_taken_out, rx_valid_out, straps_ready_out, spi_mode_out;
	logic [7:0] rx_data_out;
	logic [6:0] i2c_addr_out;
	int error_cnt = 0;
	int n_compared = 0;
	int taken_cnt = 0;
	int seed = 32'h0109;
	logic [7:0] exp_q[$];
	// Pin levels: pull-ups on released lines, the shared data pin carries SCK in SPI mode.
	wire shared_data_or_sclk_pin_in = spi_s ? sck : !(sda_low | shared_data_or_sclk_pin_oe_out);
	wire spi_sck_clk_in = shared_data_or_sclk_pin_in;
	wire shared_clock_or_select_pin_in = scl_nss;
	wire address_strap_or_mosi_pin_in = spi_s ? mosi : ads;
	wire interface_strap_or_miso_pin_in = interface_strap_or_miso_pin_oe_out ? interface_strap_or_miso_pin_out : ifs;
	wire irq_n = !host_interrupt_n_oe_out;
	his_host_select #(.STARTUP_CYCLES(SU)) uut (.ref_clk_in, .rst_n_in, .spi_sck_clk_in,
		.shared_data_or_sclk_pin_in, .shared_data_or_sclk_pin_out, .shared_data_or_sclk_pin_oe_out,
		.shared_clock_or_select_pin_in, .address_strap_or_mosi_pin_in, .interface_strap_or_miso_pin_in,
		.interface_strap_or_miso_pin_out, .interface_strap_or_miso_pin_oe_out, .host_interrupt_n_out,
		.host_interrupt_n_oe_out, .tx_data_in, .report_pending_in, .tx_taken_out, .rx_data_out,
		.rx_valid_out, .straps_ready_out, .spi_mode_out, .i2c_addr_out);
	his_host_model m (.sda_in(shared_data_or_sclk_pin_in), .miso_in(interface_strap_or_miso_pin_in),
		.scl_nss_out(scl_nss), .sda_low_out(sda_low), .sck_out(sck), .mosi_out(mosi));
	always #2.5 ref_clk_in = ~ref_clk_in;
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : report_and_stop
	// Reset with the straps set, then wait out the greeting delay.
	task automatic start_session(input logic spi);
		rst_n_in = 1'b0;
		spi_s = spi;
		ifs = spi;
		repeat (10) @(negedge ref_clk_in);
		rst_n_in = 1'b1;
		repeat (12) @(negedge ref_clk_in);
		check("spi_mode", {7'h00, spi_mode_out}, {7'h00, spi});
		check("miso_oe", {7'h00, interface_strap_or_miso_pin_oe_out}, {7'h00, spi});
		repeat (SU) @(negedge ref_clk_in);
		check("greeting", {7'h00, irq_n}, 8'h00);
	endtask : start_session
	// Each received byte is matched with the oldest byte the host sent.
	always @(posedge ref_clk_in) begin
		if (tx_taken_out === 1'b1) taken_cnt++;
		if (rx_valid_out === 1'b1) begin
			if (exp_q.size() == 0) check("rx_extra", 8'h00, 8'hFF);
			else check("rx_data", rx_data_out, exp_q.pop_front());
		end
	end
	// Main sequence: two I2C sessions, then a third reset into an SPI session.
	initial begin
		logic [7:0] r;
		logic [7:0] cur;
		logic [7:0] nxt;
		logic [7:0] mo;
		logic a;
		@(negedge ref_clk_in);
		start_session(1'b0);
		check("i2c_addr", {1'b0, i2c_addr_out}, 8'h67);
		m.i2c_start();
		m.i2c_byte({7'h66, 1'b0}, r, a);
		m.i2c_stop();
		check("other_nack", {7'h00, a}, 8'h01);
		mo = 8'($random(seed));
		m.i2c_start();
		m.i2c_byte({7'h67, 1'b0}, r, a);
		check("addr_ack", {7'h00, a}, 8'h00);
		exp_q.push_back(mo);
		m.i2c_byte(mo, r, a);
		m.i2c_stop();
		check("data_ack", {7'h00, a}, 8'h00);
		@(negedge ref_clk_in) tx_data_in = 8'($random(seed));
		taken_cnt = 0;
		m.i2c_start();
		m.i2c_byte({7'h67, 1'b1}, r, a);
		m.i2c_byte(8'hFF, r, a);
		m.i2c_stop();
		check("rd_data", r, tx_data_in);
		check("i2c_taken", 8'(taken_cnt), 8'h01);
		check("irq_clear", {7'h00, irq_n}, 8'h01);
		@(negedge ref_clk_in) report_pending_in = 1'b1;
		@(negedge ref_clk_in) check("irq_pend", {7'h00, irq_n}, 8'h00);
		report_pending_in = 1'b0;
		// A second I2C session with the address strap low swaps which address is answered.
		ads = 1'b0;
		start_session(1'b0);
		check("i2c_addr_lo", {1'b0, i2c_addr_out}, 8'h66);
		m.i2c_start();
		m.i2c_byte({7'h67, 1'b0}, r, a);
		m.i2c_stop();
		check("other_nack_lo", {7'h00, a}, 8'h01);
		m.i2c_start();
		m.i2c_byte({7'h66, 1'b0}, r, a);
		m.i2c_stop();
		check("addr_ack_lo", {7'h00, a}, 8'h00);
		$display("test i2c done");
		cur = 8'($random(seed));
		tx_data_in = cur;
		start_session(1'b1);
		taken_cnt = 0;
		// Two bytes in a framed select, then select stays low for the rest of the run.
		for (int k = 0; k < 4; k++) begin
			if (k == 0 || k == 2) begin
				m.set_sel(1'b0);
				repeat (6) @(negedge ref_clk_in);
			end
			nxt = 8'($random(seed));
			mo = 8'($random(seed));
			tx_data_in = nxt;
			exp_q.push_back(mo);
			m.spi_byte(mo, r);
			check("miso", r, cur);
			cur = nxt;
			repeat (8) @(negedge ref_clk_in);
			if (k == 1) begin
				m.set_sel(1'b1);
				repeat (6) @(negedge ref_clk_in);
			end
		end
		check("rx_left", 8'(exp_q.size()), 8'h00);
		check("spi_taken", 8'(taken_cnt), 8'h04);
		$display("test spi done");
		report_and_stop();
	end
	// Watchdog well beyond the expected run length.
	initial begin
		#400_000;
		error_cnt++;
		$display("watchdog expired");
		report_and_stop();
	end
endmodule : tb_top
